/* File: bench/mhp_sva.sv */
`timescale 1ns/1ps
module mhp_sva (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic int_n,
  input wire logic [7:0] gpio_dev_oe,
  input wire logic [7:0] gpio_level,
  input wire logic ext_controller_select_in
);
  logic seen;
  logic [7:0] base_q;
  logic [7:0] lo_q;
  wire logic key_go = wr && addr_lo == 8'h00 && wdata == mhp_pkg::KEY[63:56];
  wire logic in_win = seen && gpio_level == base_q;
  wire logic odd_misc = wr && in_win && addr_lo == 8'h01;
  // Base taken from the first key run only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seen <= 1'b0;
      base_q <= 8'h00;
    end else if (key_go && !seen) begin
      seen <= 1'b1;
      base_q <= gpio_level;
    end
  end
  always_ff @(posedge clk_in) begin
    if (wr && in_win && !addr_lo[0]) begin
      lo_q <= wdata;
    end
  end
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_key_first;
    key_go && !$past(wr);
  endsequence
  sequence s_key_tail;
    (wr && addr_lo == 8'h00 && $stable(gpio_level)) [*7];
  endsequence
  a_key_order: assert property (s_key_first |=> s_key_tail)
    else $error("key bytes not back to back on one port");
  a_key_byte: assert property (s_key_first |=> wdata == mhp_pkg::KEY[55:48])
    else $error("second key byte wrong");
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data without a read");
  a_outside_zero: assert property (rd && !in_win |=> rdata == 8'h00)
    else $error("read outside window answered");
  a_strobe_excl: assert property (!(wr && rd))
    else $error("read and write strobes together");
  a_pins_released: assert property (ext_controller_select_in |-> gpio_dev_oe == 8'h00)
    else $error("shared pins driven while controller selected");
  a_int_clear: assert property (odd_misc && lo_q[5] |=> int_n)
    else $error("interrupt not cleared");
  a_int_disable: assert property (odd_misc && !lo_q[6] |=> int_n [*4])
    else $error("interrupt low while disabled");
  a_int_reset: assert property ($rose(rst_n_in) |-> int_n)
    else $error("interrupt low after reset");
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] BASE = 8'h5a;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [16:0] ca = 17'h00000;
  logic [7:0] cd = 8'h00;
  logic cw = 1'b0;
  logic cr = 1'b0;
  logic cap = 1'b0;
  logic cmp = 1'b0;
  logic jm = 1'b0;
  logic sel = 1'b1;
  logic ack = 1'b0;
  logic [15:0] drd = 16'h0000;
  logic [5:0] idx = 6'h00;
  logic req, dwe, irq;
  logic [20:0] daddr;
  logic [15:0] dwd, iword, tlen, vid, pid;
  logic [6:0] icnt;
  logic [7:0] crd;
  int fail_count = 0;
  int tests_run = 0;
  mhp_if mhp_if_i ();
  mhp_host mhp_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(mhp_if_i.mcu),
    .cmd_addr_in(ca), .cmd_wdata_in(cd), .cmd_wr_in(cw), .cmd_rd_in(cr),
    .cmd_rdata_out(crd), .irq_out(irq));
  mhp_device mhp_device_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(mhp_if_i.device),
    .ext_controller_select_in(sel), .capture_done_in(cap), .compress_done_in(cmp),
    .jpeg_mode_in(jm), .dram_req_out(req), .dram_we_out(dwe), .dram_addr_out(daddr),
    .dram_wdata_out(dwd), .dram_ack_in(ack), .dram_rdata_in(drd), .ident_idx_in(idx),
    .ident_word_out(iword), .ident_count_out(icnt), .table_length_out(tlen),
    .vendor_id_out(vid), .product_id_out(pid));
  mhp_sva mhp_sva_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_lo(mhp_if_i.addr_lo),
    .wdata(mhp_if_i.wdata), .rdata(mhp_if_i.rdata), .wr(mhp_if_i.wr), .rd(mhp_if_i.rd),
    .int_n(mhp_if_i.int_n), .gpio_dev_oe(mhp_if_i.gpio_dev_oe),
    .gpio_level(mhp_if_i.gpio_level), .ext_controller_select_in(sel));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [16:0] ra(input logic [7:0] o);
    return {1'b0, BASE, o};
  endfunction
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge clk_in);
    ca <= a;
    cd <= d;
    cw <= 1'b1;
    @(posedge clk_in);
    cw <= 1'b0;
    #1;
  endtask
  // Low byte then high byte of one register
  task automatic w2(input logic [7:0] o, input logic [7:0] lo, input logic [7:0] hi);
    wr(ra(o), lo);
    wr(ra(o + 8'h01), hi);
  endtask
  task automatic rreg(input logic [16:0] a, input logic [7:0] e);
    @(posedge clk_in);
    ca <= a;
    cr <= 1'b1;
    @(posedge clk_in);
    cr <= 1'b0;
    #1;
    chk(21'(crd), 21'(e));
  endtask
  task automatic key(input logic [7:0] b);
    wr(17'h10001, b);
    repeat (12) @(posedge clk_in);
    #1;
  endtask
  // Raw back-to-back key run through the pass-through path, last byte given
  task automatic kburst(input logic [7:0] last);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_in);
      ca <= {1'b0, BASE, 8'h00};
      cd <= (k == 7) ? last : mhp_pkg::KEY[8*(mhp_pkg::KEY_LEN-1-k) +: 8];
      cw <= 1'b1;
    end
    @(posedge clk_in);
    cw <= 1'b0;
    #1;
  endtask
  task automatic misc(input logic [7:0] lo, input logic e);
    w2(8'h00, lo, 8'hff);
    chk(21'(mhp_if_i.int_n), 21'(e));
  endtask
  task automatic ev(input logic j, input logic c, input logic m, input logic e);
    @(posedge clk_in);
    jm <= j;
    cap <= c;
    cmp <= m;
    @(posedge clk_in);
    cap <= 1'b0;
    cmp <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(21'(mhp_if_i.int_n), 21'(e));
    chk(21'(irq), 21'(!e));
  endtask
  task automatic dram(input logic we, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (req !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk(21'(req), 21'h1);
    chk(21'(dwe), 21'(we));
    chk(daddr, a);
    if (we) chk(21'(dwd), 21'(d));
    @(posedge clk_in);
    ack <= 1'b1;
    drd <= d;
    @(posedge clk_in);
    ack <= 1'b0;
    #1;
  endtask
  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rreg(17'h10000, 8'h00);
    rreg(ra(8'h02), 8'h00);
    w2(8'h00, 8'h40, 8'hff);
    kburst(8'h00);
    rreg(ra(8'h02), 8'h00);
    key(BASE);
    rreg(17'h10000, 8'h04);
    rreg(ra(8'h02), 8'h01);
    rreg(ra(8'h03), 8'h02);
    rreg(ra(8'h00), 8'h00);
    rreg({1'b0, 8'h5b, 8'h02}, 8'h00);
    key(8'h33);
    rreg({1'b0, 8'h33, 8'h02}, 8'h00);
    w2(8'h04, 8'hff, 8'hff);
    chk(21'(mhp_if_i.gpio_dev_oe), 21'h0);
    rreg(ra(8'h02), 8'h01);
    misc(8'h40, 1'b1);
    ev(1'b0, 1'b0, 1'b1, 1'b1);
    ev(1'b0, 1'b1, 1'b0, 1'b0);
    rreg(17'h10000, 8'h05);
    misc(8'h60, 1'b1);
    rreg(ra(8'h00), 8'h40);
    ev(1'b1, 1'b1, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b1, 1'b0);
    misc(8'h00, 1'b1);
    ev(1'b1, 1'b0, 1'b1, 1'b1);
    misc(8'h40, 1'b0);
    misc(8'h60, 1'b1);
    w2(8'h18, 8'h34, 8'h12);
    w2(8'h1a, 8'h1f, 8'h01);
    w2(8'h1c, 8'hcd, 8'hab);
    dram(1'b1, 21'h1f1234, 16'habcd);
    w2(8'h1c, 8'h11, 8'h22);
    dram(1'b1, 21'h1f1235, 16'h2211);
    w2(8'h18, 8'hff, 8'hff);
    w2(8'h1a, 8'hff, 8'h00);
    dram(1'b0, 21'h1fffff, 16'hbeef);
    rreg(ra(8'h1c), 8'hef);
    rreg(ra(8'h1d), 8'hbe);
    dram(1'b0, 21'h000000, 16'h1357);
    rreg(ra(8'h1c), 8'h57);
    rreg(ra(8'h1d), 8'h13);
    dram(1'b0, 21'h000001, 16'h0000);
    w2(8'h1e, 8'h0a, 8'h00);
    w2(8'h1e, 8'h34, 8'h12);
    w2(8'h1e, 8'h78, 8'h56);
    chk(21'(tlen), 21'h00000a);
    chk(21'(vid), 21'h001234);
    chk(21'(pid), 21'h005678);
    chk(21'(icnt), 21'h3);
    @(posedge clk_in);
    idx <= 6'h01;
    #1;
    chk(21'(iword), 21'h001234);
    for (int i = 3; i < 65; i++) begin
      w2(8'h1e, 8'(i), 8'h00);
    end
    @(posedge clk_in);
    idx <= 6'h3f;
    #1;
    chk(21'(icnt), 21'd64);
    chk(21'(iword), 21'h00003f);
    chk(21'(tlen), 21'h00000a);
    @(posedge clk_in);
    sel <= 1'b0;
    #1;
    chk(21'(mhp_if_i.gpio_dev_oe), 21'hff);
    chk(21'(mhp_if_i.gpio_dev_out), 21'hff);
    rreg(ra(8'h02), 8'h00);
    @(posedge clk_in);
    sel <= 1'b1;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rreg(ra(8'h02), 8'h00);
    key(8'h33);
    rreg({1'b0, 8'h33, 8'h02}, 8'h01);
    report_and_stop;
  end
endmodule

/* File: src/mhp_device.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// R1 - Registers decoded in 256-byte window at base
// R2 - Eight-byte key at xx00H sets base
// R3 - Key after reset; base fixed until reset
// R4 - 16-bit registers as low then high byte
// R5 - Interrupt low on capture done outside JPEG mode, on compression done in JPEG mode
// R6 - Controller writes one to clear interrupt
// R7 - Writing zero to enable disables interrupt
// R8 - Disabled interrupt output held high
// R9 - DRAM word address written as three bytes
// R10 - Mode bit zero reads, one writes
// R11 - Read mode fetches word, then increments address
// R12 - High data byte read fetches next word
// R13 - High data byte write stores word, increments
// R14 - Identity block: length, vendor, product words
// R15 - At most 128 identity bytes accepted
// R16 - Identity words written in order after setup
// R17 - Selected controller owns general pins as address
// R18 - Status bit shows controller select pin
// R19 - Accesses before setup or outside window ignored
// R20 - Wrong key byte restarts matching
module mhp_device (
  input wire logic clk_in,
  input wire logic rst_n_in,
  mhp_if.device bus,
  input wire logic ext_controller_select_in,
  input wire logic capture_done_in,
  input wire logic compress_done_in,
  input wire logic jpeg_mode_in,
  output logic dram_req_out,
  output logic dram_we_out,
  output logic [20:0] dram_addr_out,
  output logic [15:0] dram_wdata_out,
  input wire logic dram_ack_in,
  input wire logic [15:0] dram_rdata_in,
  input wire logic [5:0] ident_idx_in,
  output logic [15:0] ident_word_out,
  output logic [6:0] ident_count_out,
  output logic [15:0] table_length_out,
  output logic [15:0] vendor_id_out,
  output logic [15:0] product_id_out
);
  typedef enum logic [1:0] {D_IDLE, D_READ, D_WRITE} mhp_dram_e;

  mhp_dram_e dstate;
  mhp_dram_e next_dstate;
  logic [15:0] misc;
  logic [15:0] gpio_ctrl;
  logic [7:0] wlow;
  logic irq_pending;
  logic [20:0] daddr;
  logic dmode_write;
  logic [15:0] dlatch;
  logic [15:0] dwword;
  logic [7:0] rdata;
  logic [6:0] vcount;
  logic [15:0] ident_mem [mhp_pkg::IDENT_WORDS];
  logic base_valid;
  logic [7:0] base_hi;

  mhp_key_match u_key (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(bus.wr),
    .addr_in({bus.gpio_level, bus.addr_lo}),
    .data_in(bus.wdata),
    .base_valid_out(base_valid),
    .base_hi_out(base_hi)
  );

  // Window decode
  wire in_window = base_valid && ext_controller_select_in
    && (bus.gpio_level == base_hi); // R1 R19
  wire wr_hit = bus.wr && in_window;
  wire rd_hit = bus.rd && in_window;
  wire [7:0] off = bus.addr_lo;
  wire wr_even = wr_hit && !off[0];
  wire [15:0] wr_word = {bus.wdata, wlow};
  wire misc_commit = wr_hit && (off == (mhp_pkg::OFF_MISC | 8'h01)); // R4
  wire gpio_commit = wr_hit && (off == (mhp_pkg::OFF_GPIO | 8'h01));
  wire vstr_commit = wr_hit && (off == mhp_pkg::OFF_VSTR_HI);
  wire vstr_room = (vcount < 7'(mhp_pkg::IDENT_WORDS)); // R15
  wire dmode_wr = wr_hit && (off == mhp_pkg::OFF_DMODE);
  wire dhi_wr = wr_hit && (off == mhp_pkg::OFF_DDATA_HI);
  wire dhi_rd = rd_hit && (off == mhp_pkg::OFF_DDATA_HI);
  wire dram_idle = (dstate == D_IDLE);

  // Interrupt
  wire irq_event = jpeg_mode_in ? compress_done_in : capture_done_in; // R5
  wire irq_clear = misc_commit && wlow[mhp_pkg::MISC_IRQ_CLR_BIT]; // R6
  wire irq_en = misc[mhp_pkg::MISC_IRQ_EN_BIT];
  wire next_irq_pending = irq_event || (irq_pending && !irq_clear);

  // DRAM start triggers
  wire start_read = (dmode_wr && !bus.wdata[mhp_pkg::DMODE_WRITE_BIT])
    || (dhi_rd && !dmode_write); // R11 R12
  wire start_write = dhi_wr && dmode_write && dram_idle; // R13
  wire dram_done = !dram_idle && dram_ack_in;

  always_comb begin
    next_dstate = dstate;
    case (dstate)
      D_IDLE: begin
        if (start_read) begin
          next_dstate = D_READ;
        end else if (start_write) begin
          next_dstate = D_WRITE;
        end
      end
      D_READ: begin
        if (dram_ack_in) begin
          next_dstate = D_IDLE;
        end
      end
      D_WRITE: begin
        if (dram_ack_in) begin
          next_dstate = D_IDLE;
        end
      end
      default: begin
        next_dstate = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dstate <= D_IDLE;
    end else begin
      dstate <= next_dstate;
    end
  end

  // Control registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      misc <= mhp_pkg::MISC_RESET;
      gpio_ctrl <= mhp_pkg::GPIO_RESET;
      wlow <= 8'h00;
      irq_pending <= 1'b0;
    end else begin
      irq_pending <= next_irq_pending;
      if (wr_even) begin
        wlow <= bus.wdata;
      end
      if (misc_commit) begin
        misc <= wr_word & ~(16'h0001 << mhp_pkg::MISC_IRQ_CLR_BIT); // R7
      end
      if (gpio_commit) begin
        gpio_ctrl <= wr_word;
      end
    end
  end

  // DRAM address, mode and data path
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      daddr <= 21'h000000;
      dmode_write <= 1'b0;
      dlatch <= 16'h0000;
      dwword <= 16'h0000;
    end else begin
      if (dram_done) begin
        daddr <= daddr + 21'h000001; // R11 R13
      end
      if (wr_hit && off == mhp_pkg::OFF_DADDR0) begin
        daddr[7:0] <= bus.wdata; // R9
      end
      if (wr_hit && off == mhp_pkg::OFF_DADDR1) begin
        daddr[15:8] <= bus.wdata; // R9
      end
      if (wr_hit && off == mhp_pkg::OFF_DADDR2) begin
        daddr[20:16] <= bus.wdata[mhp_pkg::DRAM_HI_W-1:0]; // R9
      end
      if (dmode_wr) begin
        dmode_write <= bus.wdata[mhp_pkg::DMODE_WRITE_BIT]; // R10
      end
      if (dstate == D_READ && dram_ack_in) begin
        dlatch <= dram_rdata_in; // R11
      end
      if (start_write) begin
        dwword <= wr_word; // R13
      end
    end
  end

  // Identity store, one entry per word
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vcount <= 7'h00;
    end else if (vstr_commit && vstr_room) begin
      vcount <= vcount + 7'h01; // R16
    end
  end

  for (genvar i = 0; i < mhp_pkg::IDENT_WORDS; i++) begin : g_ident
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        ident_mem[i] <= 16'h0000;
      end else if (vstr_commit && vstr_room && vcount[5:0] == 6'(i)) begin
        ident_mem[i] <= wr_word; // R16
      end
    end
  end

  // Read data, valid the cycle after the strobe
  wire [15:0] status = (16'(ext_controller_select_in) << mhp_pkg::STAT_EXT_SEL_BIT)
    | (16'(!dram_idle) << mhp_pkg::STAT_DRAM_BUSY_BIT)
    | (16'(base_valid) << mhp_pkg::STAT_BASE_OK_BIT); // R18
  logic [7:0] next_rdata;
  always_comb begin
    case (off)
      mhp_pkg::OFF_MISC: next_rdata = misc[7:0];
      mhp_pkg::OFF_MISC | 8'h01: next_rdata = misc[15:8];
      mhp_pkg::OFF_STATUS: next_rdata = status[7:0];
      mhp_pkg::OFF_STATUS | 8'h01: next_rdata = status[15:8];
      mhp_pkg::OFF_GPIO: next_rdata = gpio_ctrl[7:0];
      mhp_pkg::OFF_GPIO | 8'h01: next_rdata = gpio_ctrl[15:8];
      mhp_pkg::OFF_DADDR0: next_rdata = daddr[7:0];
      mhp_pkg::OFF_DADDR1: next_rdata = daddr[15:8];
      mhp_pkg::OFF_DADDR2: next_rdata = {3'h0, daddr[20:16]};
      mhp_pkg::OFF_DMODE: next_rdata = {7'h00, dmode_write};
      mhp_pkg::OFF_DDATA_LO: next_rdata = dlatch[7:0]; // R12
      mhp_pkg::OFF_DDATA_HI: next_rdata = dlatch[15:8]; // R12
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata <= 8'h00;
    end else if (rd_hit) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00; // R19
    end
  end

  assign bus.rdata = rdata;
  assign bus.int_n = !(irq_pending && irq_en); // R5 R8
  assign bus.gpio_dev_out = gpio_ctrl[7:0];
  assign bus.gpio_dev_oe = ext_controller_select_in ? 8'h00 : gpio_ctrl[15:8]; // R17

  assign dram_req_out = !dram_idle;
  assign dram_we_out = (dstate == D_WRITE);
  assign dram_addr_out = daddr;
  assign dram_wdata_out = dwword;

  assign ident_word_out = ident_mem[ident_idx_in];
  assign ident_count_out = vcount;
  assign table_length_out = ident_mem[mhp_pkg::IDENT_LEN_IDX]; // R14
  assign vendor_id_out = ident_mem[mhp_pkg::IDENT_VENDOR_IDX]; // R14
  assign product_id_out = ident_mem[mhp_pkg::IDENT_PRODUCT_IDX]; // R14
endmodule

/* File: src/mhp_host.sv */
`timescale 1ns/1ps
module mhp_host (
  input wire logic clk_in,
  input wire logic rst_n_in,
  mhp_if.mcu bus,
  input wire logic [16:0] cmd_addr_in,
  input wire logic [7:0] cmd_wdata_in,
  input wire logic cmd_wr_in,
  input wire logic cmd_rd_in,
  output logic [7:0] cmd_rdata_out,
  output logic irq_out
);
  typedef enum logic {H_IDLE, H_KEY} mhp_host_e;

  mhp_host_e hstate;
  logic [2:0] kidx;
  logic [7:0] seq_base;
  logic key_done;
  logic last_local;
  logic [7:0] local_rdata;

  wire local_sel = cmd_addr_in[mhp_pkg::HOST_SEL_BIT];
  wire busy = (hstate == H_KEY);
  wire key_cmd = cmd_wr_in && local_sel && !busy
    && (cmd_addr_in[7:0] == mhp_pkg::HOST_OFF_KEY); // R2 R3
  wire [7:0] key_byte = mhp_pkg::KEY[8*(mhp_pkg::KEY_LEN-1-int'(kidx)) +: 8];
  wire pass = !busy && !local_sel;
  wire [7:0] status = {5'h00, key_done, busy, !bus.int_n};

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hstate <= H_IDLE;
      kidx <= 3'h0;
      seq_base <= 8'h00;
      key_done <= 1'b0;
    end else begin
      case (hstate)
        H_IDLE: begin
          if (key_cmd) begin
            hstate <= H_KEY;
            kidx <= 3'h0;
            seq_base <= cmd_wdata_in;
          end
        end
        H_KEY: begin
          kidx <= kidx + 3'h1;
          if (kidx == 3'h7) begin
            hstate <= H_IDLE;
            key_done <= 1'b1;
          end
        end
        default: begin
          hstate <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_local <= 1'b0;
      local_rdata <= 8'h00;
    end else begin
      last_local <= local_sel || busy;
      local_rdata <= (cmd_rd_in && local_sel && !busy
        && cmd_addr_in[7:0] == mhp_pkg::HOST_OFF_STATUS) ? status : 8'h00;
    end
  end

  // Key bytes go to the chosen xx00H port, one per cycle
  assign bus.addr_lo = busy ? mhp_pkg::KEY_PORT_LO : cmd_addr_in[7:0]; // R2
  assign bus.addr_hi = busy ? seq_base : cmd_addr_in[15:8];
  assign bus.wdata = busy ? key_byte : cmd_wdata_in;
  assign bus.wr = busy || (pass && cmd_wr_in);
  assign bus.rd = pass && cmd_rd_in;
  assign cmd_rdata_out = last_local ? local_rdata : bus.rdata;
  assign irq_out = !bus.int_n; // R6
endmodule

/* File: src/mhp_if.sv */
`timescale 1ns/1ps
interface mhp_if;
  logic [7:0] addr_lo;
  logic [7:0] addr_hi;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic int_n;
  logic [7:0] gpio_dev_out;
  logic [7:0] gpio_dev_oe;
  logic [7:0] gpio_level;

  // Shared pins: device drive wins where enabled, else the upper address
  assign gpio_level = (gpio_dev_oe & gpio_dev_out) | (~gpio_dev_oe & addr_hi);

  modport device (
    input addr_lo, gpio_level, wdata, wr, rd,
    output rdata, int_n, gpio_dev_out, gpio_dev_oe
  );
  modport mcu (
    output addr_lo, addr_hi, wdata, wr, rd,
    input rdata, int_n
  );
endinterface

/* File: src/mhp_key_match.sv */
`timescale 1ns/1ps
module mhp_key_match (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] data_in,
  output logic base_valid_out,
  output logic [7:0] base_hi_out
);
  logic [2:0] idx;
  logic valid;
  logic [7:0] base_hi;
  wire [7:0] exp_byte = mhp_pkg::KEY[8*(mhp_pkg::KEY_LEN-1-int'(idx)) +: 8];
  wire [7:0] first_byte = mhp_pkg::KEY[8*(mhp_pkg::KEY_LEN-1) +: 8];
  wire port_lo = (addr_in[7:0] == mhp_pkg::KEY_PORT_LO);
  wire same_port = (idx == 3'h0) || (addr_in[15:8] == base_hi);
  wire hit = port_lo && same_port && (data_in == exp_byte);
  wire restart_one = port_lo && (data_in == first_byte);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      idx <= 3'h0;
      valid <= 1'b0;
      base_hi <= 8'h00;
    end else if (wr_in && !valid) begin // R3
      base_hi <= addr_in[15:8];
      if (hit) begin
        idx <= idx + 3'h1;
        if (idx == 3'h7) begin
          valid <= 1'b1; // R2
        end
      end else begin
        idx <= restart_one ? 3'h1 : 3'h0; // R20
      end
    end
  end

  assign base_valid_out = valid;
  assign base_hi_out = base_hi;
endmodule

/* File: src/mhp_pkg.sv */
package mhp_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int DRAM_AW = 21;
  localparam int DRAM_HI_W = 5;

  // Register offsets inside the 256-byte window
  localparam logic [7:0] OFF_MISC = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h02;
  localparam logic [7:0] OFF_GPIO = 8'h04;
  localparam logic [7:0] OFF_DADDR0 = 8'h18;
  localparam logic [7:0] OFF_DADDR1 = 8'h19;
  localparam logic [7:0] OFF_DADDR2 = 8'h1a;
  localparam logic [7:0] OFF_DMODE = 8'h1b;
  localparam logic [7:0] OFF_DDATA_LO = 8'h1c;
  localparam logic [7:0] OFF_DDATA_HI = 8'h1d;
  localparam logic [7:0] OFF_VSTR_LO = 8'h1e;
  localparam logic [7:0] OFF_VSTR_HI = 8'h1f;
  localparam logic [7:0] KEY_PORT_LO = 8'h00;

  // Field positions
  localparam int MISC_IRQ_CLR_BIT = 5;
  localparam int MISC_IRQ_EN_BIT = 6;
  localparam int STAT_EXT_SEL_BIT = 9;
  localparam int STAT_DRAM_BUSY_BIT = 1;
  localparam int STAT_BASE_OK_BIT = 0;
  localparam int DMODE_WRITE_BIT = 0;

  // Reset values
  localparam logic [15:0] MISC_RESET = 16'hff00;
  localparam logic [15:0] GPIO_RESET = 16'h0000;

  // Key: arbitrary value, eight bytes sent first byte first
  localparam int KEY_LEN = 8;
  localparam logic [63:0] KEY = 64'h4b_45_59_5f_4d_41_54_43;

  // Identity data block
  localparam int IDENT_WORDS = 64;
  localparam int IDENT_IDX_W = 6;
  localparam int IDENT_LEN_IDX = 0;
  localparam int IDENT_VENDOR_IDX = 1;
  localparam int IDENT_PRODUCT_IDX = 2;

  // Host local command space
  localparam int HOST_SEL_BIT = 16;
  localparam logic [7:0] HOST_OFF_STATUS = 8'h00;
  localparam logic [7:0] HOST_OFF_KEY = 8'h01;
endpackage
